/* src/lrp_pkg.sv */
// Purpose: Shared constants and carriers for the LCD reset/power-state block
// Assumes: Commands arrive already decoded into bytes on the core clock
// Notes:   Command byte codes are held here so decode and checks agree
package lrp_pkg;

    // ------------------------------------------------------------------
    // Command codes and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] LRP_CMD_DISP_OFF  = 8'hAE; // Display off
    localparam logic [7:0] LRP_CMD_DISP_ON   = 8'hAF; // Display on
    localparam logic [7:0] LRP_CMD_NORMAL    = 8'hA6; // Polarity normal
    localparam logic [7:0] LRP_CMD_REVERSE   = 8'hA7; // Polarity reversed
    localparam logic [7:0] LRP_CMD_ALL_OFF   = 8'hA4; // All points normal
    localparam logic [7:0] LRP_CMD_ALL_ON    = 8'hA5; // All points on
    localparam logic [7:0] LRP_CMD_SEG_NORM  = 8'hA0; // Segment normal
    localparam logic [7:0] LRP_CMD_SEG_REV   = 8'hA1; // Segment reversed
    localparam logic [7:0] LRP_CMD_BIAS_5    = 8'hA2; // Bias one-fifth
    localparam logic [7:0] LRP_CMD_BIAS_6    = 8'hA3; // Bias one-sixth
    localparam logic [7:0] LRP_CMD_RMW       = 8'hE0; // Read-modify-write
    localparam logic [7:0] LRP_CMD_END       = 8'hEE; // End RMW
    localparam logic [7:0] LRP_CMD_RESET     = 8'hE2; // Soft reset
    localparam logic [7:0] LRP_CMD_NL_CANCEL = 8'hE4; // Cancel n-line inv
    localparam logic [7:0] LRP_MSK_HI5       = 8'hF8; // Top five bits
    localparam logic [7:0] LRP_MSK_HI4       = 8'hF0; // Top four bits
    localparam logic [7:0] LRP_MSK_HI3       = 8'hE0; // Top three bits
    localparam logic [7:0] LRP_CMD_PWR       = 8'h28; // Power control base
    localparam logic [7:0] LRP_CMD_RATIO     = 8'h20; // Resistor ratio base
    localparam logic [7:0] LRP_CMD_NL_SET    = 8'h30; // n-line inversion set
    localparam logic [7:0] LRP_CMD_COL_LO    = 8'h00; // Column low nibble
    localparam logic [7:0] LRP_CMD_COL_HI    = 8'h10; // Column high bits
    localparam logic [7:0] LRP_CMD_LINE      = 8'h40; // Start line base
    localparam logic [7:0] LRP_CMD_VOL       = 8'h80; // Electronic volume
    localparam logic [7:0] LRP_CMD_PAGE      = 8'hB0; // Page base
    localparam logic [7:0] LRP_CMD_COM       = 8'hC0; // Common direction
    localparam logic [7:0] LRP_CMD_TEST      = 8'hF0; // Test mode entry

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [2:0] LRP_PWR_RST       = 3'h0;
    localparam logic [2:0] LRP_RATIO_RST     = 3'h0;
    localparam logic [2:0] LRP_RATIO_EXT     = 3'h7; // External divider
    localparam logic [4:0] LRP_VOL_RST       = 5'h10;
    localparam logic [6:0] LRP_COL_LAST      = 7'h65;
    localparam logic [2:0] LRP_PAGE_LAST     = 3'h3;
    localparam int         LRP_PWR_BOOST     = 2;
    localparam int         LRP_PWR_REG       = 1;
    localparam int         LRP_PWR_FOLLOW    = 0;

    // Decoded command strobe from the host port, same clock
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } lrp_cmd_s;

    // Display-memory access strobes used for address stepping
    typedef struct packed {
        logic wr;
        logic rd;
    } lrp_mem_s;

    // Complete visible state of the block
    typedef struct packed {
        logic       disp_on;
        logic       all_on;
        logic       reverse;
        logic       power_save;
        logic       osc_en;
        logic [2:0] supply_en;
        logic       bias_sixth;
        logic [2:0] page;
        logic [6:0] column;
        logic [4:0] start_line;
        logic       seg_rev;
        logic       com_rev;
        logic       nline_en;
        logic       rmw;
        logic       test_mode;
        logic [2:0] pwr_ctl;
        logic [2:0] ratio;
        logic [4:0] volume;
        logic       int_div_en;
        logic       ext_fb_en;
        logic       drv_ground;
    } lrp_state_s;

    // Drive-level numerators over the bias denominator, V1..V4
    typedef logic [11:0] lrp_levels_t;

endpackage

/* src/lrp_core.sv */
// Purpose: Reset, power-save and supply-control state of the LCD controller
// Assumes: Host port delivers command bytes as one-cycle strobes on ref_clk
// Notes:   Display memory lives elsewhere; this block never writes it
//
// What this block does
// - Bias selectable one-fifth or one-sixth, levels follow.
// - Pin or command reset clears serial shifter.
// - Reset enters power save, stops oscillator, supply.
// - Reset: display off, all-on, normal, outputs grounded.
// - Reset zeroes page, column, start line.
// - Reset restores segment and common directions.
// - Reset cancels inversion, RMW and test mode.
// - Reset clears power and ratio settings.
// - Reset loads electronic volume with binary 10000.
// - Reset leaves display memory untouched.
// - Discharge shorts only while reset pin low or block reset asserted.
// - Feedback input active only with external divider.
// - Power bits: booster, regulator, follower enables.
// - Ratio 111 deselects the internal divider.
// - Display off with all-on enters power save.
`timescale 1ns/1ps
module lrp_core
    import lrp_pkg::*;
(
    input  wire logic        ref_clk,      // 50 MHz core clock
    input  wire logic        reset,        // Async, active high
    input  wire logic        init_low_pin, // Reset pin, active low, async
    input  wire lrp_cmd_s    cmd,          // Command byte strobe
    input  wire lrp_mem_s    mem,          // Memory access strobes
    output lrp_state_s       state,        // Registered device state
    output lrp_levels_t      levels,       // V1..V4 numerators
    output logic             serial_clear, // Clears serial shifter
    output logic             discharge     // Closes discharge shorts
);

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic       pin_meta_reg;    // First stage, read only by second
    logic       pin_sync_reg;    // Safe level of the reset pin
    logic       pin_low;         // Pin currently asserted

    // Two flops: the pin is asynchronous to ref_clk
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= init_low_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign pin_low = ~pin_sync_reg;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Match a byte against a base under a mask
    function automatic logic hit(input logic [7:0] code,
                                 input logic [7:0] base,
                                 input logic [7:0] msk);
        hit = (code & msk) == base;
    endfunction

    // Intermediate drive levels as numerators over 5 or 6
    function automatic lrp_levels_t bias_levels(input logic sixth);
        bias_levels = sixth ? {3'h5, 3'h4, 3'h2, 3'h1}
                            : {3'h4, 3'h3, 3'h2, 3'h1};
    endfunction

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    lrp_state_s  st_reg;          // Current state
    lrp_state_s  st_next;         // Next state
    logic [6:0]  col_save_reg;    // Column saved at RMW entry
    logic [6:0]  col_save_next;
    lrp_levels_t lev_reg;         // Drive level numerators
    logic        sclr_reg;        // Serial clear pulse
    logic        dis_reg;         // Discharge level
    logic        do_init;         // Pin or command reset this cycle
    logic        c_hit;           // Command strobe shorthand

    // Reset image shared by the async reset and both init sources
    function automatic lrp_state_s init_state();
        lrp_state_s s;
        s            = '0;
        s.disp_on    = 1'b0;
        s.all_on     = 1'b1;
        s.reverse    = 1'b0;
        s.power_save = 1'b1;
        s.osc_en     = 1'b0;
        s.supply_en  = 3'h0;
        s.page       = 3'h0;
        s.column     = 7'h00;
        s.start_line = 5'h00;
        s.seg_rev    = 1'b0;
        s.com_rev    = 1'b0;
        s.nline_en   = 1'b0;
        s.rmw        = 1'b0;
        s.test_mode  = 1'b0;
        s.pwr_ctl    = LRP_PWR_RST;
        s.ratio      = LRP_RATIO_RST;
        s.volume     = LRP_VOL_RST;
        s.int_div_en = 1'b1;
        s.ext_fb_en  = 1'b0;
        s.drv_ground = 1'b1;
        init_state   = s;
    endfunction

    assign c_hit   = cmd.valid & ~pin_low;
    // Command reset acts like the pin except for the discharge shorts
    assign do_init = pin_low | (c_hit & (cmd.code == LRP_CMD_RESET));

    // Next-state: decode commands, step addresses, derive outputs
    always_comb begin
        st_next       = st_reg;
        col_save_next = col_save_reg;
        if (do_init) begin
            // Only control state is reloaded; memory contents stay put
            st_next = init_state();
        end else begin
            if (c_hit) begin
                // Display, polarity, segment, bias and inversion commands
                if (cmd.code == LRP_CMD_DISP_OFF)  st_next.disp_on = 1'b0;
                if (cmd.code == LRP_CMD_DISP_ON)   st_next.disp_on = 1'b1;
                if (cmd.code == LRP_CMD_NORMAL)    st_next.reverse = 1'b0;
                if (cmd.code == LRP_CMD_REVERSE)   st_next.reverse = 1'b1;
                if (cmd.code == LRP_CMD_ALL_OFF)   st_next.all_on  = 1'b0;
                if (cmd.code == LRP_CMD_ALL_ON)    st_next.all_on  = 1'b1;
                if (cmd.code == LRP_CMD_SEG_NORM)  st_next.seg_rev = 1'b0;
                if (cmd.code == LRP_CMD_SEG_REV)   st_next.seg_rev = 1'b1;
                if (cmd.code == LRP_CMD_BIAS_5)    st_next.bias_sixth = 1'b0;
                if (cmd.code == LRP_CMD_BIAS_6)    st_next.bias_sixth = 1'b1;
                if (cmd.code == LRP_CMD_NL_CANCEL) st_next.nline_en = 1'b0;
                // Power stage bits map straight to the three stages
                if (hit(cmd.code, LRP_CMD_PWR, LRP_MSK_HI5))
                    st_next.pwr_ctl = cmd.code[2:0];
                if (hit(cmd.code, LRP_CMD_RATIO, LRP_MSK_HI5))
                    st_next.ratio = cmd.code[2:0];
                if (hit(cmd.code, LRP_CMD_NL_SET, LRP_MSK_HI4))
                    st_next.nline_en = 1'b1;
                if (hit(cmd.code, LRP_CMD_VOL, LRP_MSK_HI3))
                    st_next.volume = cmd.code[4:0];
                if (hit(cmd.code, LRP_CMD_LINE, LRP_MSK_HI3))
                    st_next.start_line = cmd.code[4:0];
                if (hit(cmd.code, LRP_CMD_PAGE, LRP_MSK_HI5))
                    st_next.page = cmd.code[2:0];
                if (hit(cmd.code, LRP_CMD_COM, LRP_MSK_HI4))
                    st_next.com_rev = cmd.code[3];
                if (hit(cmd.code, LRP_CMD_TEST, LRP_MSK_HI4))
                    st_next.test_mode = 1'b1;
                // Column set is ignored inside read-modify-write
                if (!st_reg.rmw &&
                    hit(cmd.code, LRP_CMD_COL_LO, LRP_MSK_HI4))
                    st_next.column[3:0] = cmd.code[3:0];
                if (!st_reg.rmw &&
                    hit(cmd.code, LRP_CMD_COL_HI, LRP_MSK_HI5))
                    st_next.column[6:4] = cmd.code[2:0];
                if (cmd.code == LRP_CMD_RMW && !st_reg.rmw) begin
                    st_next.rmw   = 1'b1;
                    col_save_next = st_reg.column;
                end
                if (cmd.code == LRP_CMD_END && st_reg.rmw) begin
                    st_next.rmw    = 1'b0;
                    st_next.column = col_save_reg;
                end
            end else if (mem.wr || (mem.rd && !st_reg.rmw)) begin
                // Reads do not step the column during read-modify-write
                if (st_reg.column == LRP_COL_LAST) begin
                    st_next.column = 7'h00;
                    st_next.page   = (st_reg.page == LRP_PAGE_LAST) ?
                                     3'h0 : 3'(st_reg.page + 3'h1);
                end else begin
                    st_next.column = 7'(st_reg.column + 7'h01);
                end
            end
            // Power save whichever of the two commands came last
            st_next.power_save = ~st_next.disp_on & st_next.all_on;
            // Power save forces the supply off; the stored setting is
            // reapplied as soon as either condition is withdrawn
            st_next.osc_en     = ~st_next.power_save;
            st_next.supply_en  = st_next.power_save ? 3'h0
                                                    : st_next.pwr_ctl;
            st_next.int_div_en = st_next.ratio != LRP_RATIO_EXT;
            st_next.ext_fb_en  = st_next.ratio == LRP_RATIO_EXT;
            st_next.drv_ground = ~st_next.disp_on;
        end
    end

    // Register the state; outputs come straight from these flops
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_reg       <= init_state();
            col_save_reg <= 7'h00;
            lev_reg      <= bias_levels(1'b0);
            sclr_reg     <= 1'b1;
            dis_reg      <= 1'b1;
        end else begin
            st_reg       <= st_next;
            col_save_reg <= col_save_next;
            lev_reg      <= bias_levels(st_next.bias_sixth);
            sclr_reg     <= do_init;
            dis_reg      <= pin_low;
        end
    end

    assign state        = st_reg;
    assign levels       = lev_reg;
    assign serial_clear = sclr_reg;
    assign discharge    = dis_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_init_power_off: assert property (do_init |=> state.power_save &&
        !state.osc_en && state.supply_en == 3'h0)
        else $error("init did not stop supply");
    a_init_display: assert property (do_init |=> !state.disp_on &&
        state.all_on && !state.reverse && state.drv_ground)
        else $error("init display state wrong");
    a_init_addr: assert property (do_init |=> state.page == 3'h0 &&
        state.column == 7'h00 && state.start_line == 5'h00)
        else $error("init addresses not zero");
    a_init_dirs: assert property (do_init |=> !state.seg_rev &&
        !state.com_rev && !state.nline_en && !state.rmw && !state.test_mode)
        else $error("init modes not cleared");
    a_init_volume: assert property (do_init |=> state.volume == 5'h10 &&
        state.pwr_ctl == 3'h0 && state.ratio == 3'h0)
        else $error("init settings wrong");
    a_serial_clear: assert property (do_init |=> serial_clear)
        else $error("serial clear missing");
    a_discharge_pin: assert property (
        $fell(init_low_pin) ##0 init_low_pin == 1'b0 [*3] |=> discharge)
        else $error("discharge not closed");
    a_discharge_cmd: assert property (init_low_pin [*4] |-> !discharge)
        else $error("discharge with pin high");
    a_save_state: assert property (state.power_save ==
        (!state.disp_on && state.all_on))
        else $error("power save mismatch");
    a_supply_gate: assert property (state.supply_en ==
        (state.power_save ? 3'h0 : state.pwr_ctl) &&
        state.osc_en == !state.power_save)
        else $error("supply gating wrong");
    a_feedback_sel: assert property (state.ext_fb_en ==
        (state.ratio == 3'h7) && state.int_div_en == !state.ext_fb_en)
        else $error("divider select wrong");
    a_bias_levels: assert property (
        ##1 levels[11:9] == (state.bias_sixth ? 3'h5 : 3'h4))
        else $error("bias levels wrong");
    a_pwr_cmd: assert property (c_hit && !do_init &&
        cmd.code[7:3] == 5'h05 |=> state.pwr_ctl == $past(cmd.code[2:0]))
        else $error("power command not taken");

    c_power_save: cover property (state.disp_on ##[1:20] state.power_save);
    c_wake: cover property (state.power_save ##1 !state.power_save);
    c_cmd_reset: cover property (c_hit && cmd.code == 8'hE2);
    c_rmw_end: cover property (state.rmw ##[1:20] !state.rmw);

endmodule

/* tb/lrp_host_model.sv */
// Purpose: Host processor model issuing command bytes and memory strobes
// Assumes: The block samples cmd and mem on the rising edge of ref_clk
// Notes:   Idle code lines carry the inverse of the last byte sent
`timescale 1ns/1ps
module lrp_host_model
    import lrp_pkg::*;
(
    input  wire logic ref_clk, // Core clock
    output lrp_cmd_s  cmd,     // Command strobe into the block
    output lrp_mem_s  mem      // Memory access strobes
);
    // ------------------------------------------------------------------
    // Idle levels and command writes
    // ------------------------------------------------------------------
    initial begin
        cmd = '0;
        mem = '0;
    end

    // One-cycle strobe launched and dropped on falling edges
    task automatic send(input logic [7:0] code);
        @(negedge ref_clk);
        cmd.valid = 1'b1;
        cmd.code  = code;
        @(negedge ref_clk);
        cmd.valid = 1'b0;
        cmd.code  = ~code; // Stale byte must never look meaningful
    endtask

    // One memory access pulse; only one strobe is meant per call
    task automatic mem_pulse(input logic wr, input logic rd);
        @(negedge ref_clk);
        mem.wr = wr;
        mem.rd = rd;
        @(negedge ref_clk);
        mem = '0;
    endtask

    // Only the four permitted stage combinations leave the host
    task automatic set_power(input logic [2:0] p);
        if (p == 3'h7 || p == 3'h3 || p == 3'h1 || p == 3'h0) begin
            send(LRP_CMD_PWR | {5'h00, p});
        end
    endtask

    // Regulator and follower go on before divider or volume is used
    task automatic tune(input logic [2:0] r, input logic [4:0] v);
        set_power(3'h3);
        send(LRP_CMD_RATIO | {5'h00, r});
        send(LRP_CMD_VOL | {3'h0, v});
    endtask

    // Display off first, then all points on, to drain the panel
    task automatic power_off();
        send(LRP_CMD_DISP_OFF);
        send(LRP_CMD_ALL_ON);
    endtask
endmodule

/* tb/lrp_core_tb_top.sv */
// Purpose: Self-checking bench for the reset and power-state block
// Assumes: Host model drives commands on falling edges of ref_clk
// Notes:   Expected values are built here from the documented init image
`timescale 1ns/1ps
module lrp_core_tb_top;
    import lrp_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk      = 1'b0; // 50 MHz clock
    logic        reset        = 1'b1; // Block reset
    logic        init_low_pin = 1'b0; // Pin reset, held low at power-on
    lrp_cmd_s    cmd;                 // From host model
    lrp_mem_s    mem;                 // From host model
    lrp_state_s  state;               // Observed state
    lrp_levels_t levels;              // Observed drive levels
    logic        serial_clear;        // Observed shifter clear
    logic        discharge;           // Observed discharge shorts
    int          bad_count    = 0;    // Mismatches
    int          check_count  = 0;    // Comparisons
    int          cycles       = 0;    // Hang guard

    always #10 ref_clk = ~ref_clk;

    lrp_host_model u_host (.ref_clk(ref_clk), .cmd(cmd), .mem(mem));
    lrp_core u_dut (.ref_clk(ref_clk), .reset(reset),
        .init_low_pin(init_low_pin), .cmd(cmd), .mem(mem), .state(state),
        .levels(levels), .serial_clear(serial_clear),
        .discharge(discharge));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Initial image: only these fields differ from zero
    function automatic lrp_state_s init_img();
        lrp_state_s s;
        s            = '0;
        s.all_on     = 1'b1;
        s.power_save = 1'b1;
        s.volume     = LRP_VOL_RST;
        s.int_div_en = 1'b1;
        s.drv_ground = 1'b1;
        return s;
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Whole run is about 140 cycles; a hang ends far beyond that
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        // Power-on: pin and block reset both asserted first
        tick(10);
        check(48'(state), 48'(init_img()));
        check(48'(levels), 48'h8D1);
        check(48'({serial_clear, discharge}), 48'h3);
        tick(10);
        reset        = 1'b0;
        init_low_pin = 1'b1;
        tick(6);
        check(48'({serial_clear, discharge}), 48'h0);
        check(48'(state), 48'(init_img()));
        $display("test reset done");

        // Stored power setting applies only once power save is left
        u_host.set_power(3'h7);
        tick(1);
        check(48'({state.pwr_ctl, state.supply_en}), 48'h38);
        u_host.send(LRP_CMD_DISP_ON);
        tick(1);
        check(48'({state.power_save, state.osc_en, state.supply_en,
                   state.drv_ground}), 48'h1E);
        u_host.send(LRP_CMD_ALL_OFF);
        u_host.send(LRP_CMD_DISP_OFF);
        tick(1);
        check(48'(state.power_save), 48'h0);
        u_host.send(LRP_CMD_ALL_ON);
        tick(1);
        check(48'({state.power_save, state.osc_en, state.supply_en}),
              48'h10);
        u_host.send(LRP_CMD_ALL_OFF);
        tick(1);
        check(48'({state.power_save, state.osc_en, state.supply_en}),
              48'h0F);
        u_host.send(LRP_CMD_DISP_ON);
        u_host.send(LRP_CMD_ALL_ON);
        tick(1);
        check(48'(state.power_save), 48'h0);
        u_host.send(LRP_CMD_DISP_OFF);
        tick(1);
        check(48'({state.power_save, state.supply_en}), 48'h8);
        u_host.send(LRP_CMD_DISP_ON);
        u_host.send(LRP_CMD_ALL_OFF);
        u_host.power_off();
        tick(1);
        check(48'({state.power_save, state.supply_en}), 48'h8);
        $display("test power save done");

        // Bias ratio and its drive levels
        u_host.send(LRP_CMD_BIAS_6);
        tick(1);
        check(48'({state.bias_sixth, levels}), 48'h1B11);
        u_host.send(LRP_CMD_BIAS_5);
        tick(1);
        check(48'({state.bias_sixth, levels}), 48'h08D1);
        $display("test bias done");

        // Divider selection steers the feedback input
        u_host.tune(3'h7, 5'h1F);
        tick(1);
        check(48'({state.ratio, state.int_div_en, state.ext_fb_en}),
              48'h1D);
        check(48'({state.pwr_ctl, state.volume}), 48'h7F);
        u_host.tune(3'h3, 5'h10);
        tick(1);
        check(48'({state.ratio, state.int_div_en, state.ext_fb_en}),
              48'h0E);
        $display("test divider done");

        // Address wrap at the last column and page, reads held in RMW
        u_host.send(LRP_CMD_PAGE | 8'h03);
        u_host.send(LRP_CMD_COL_HI | 8'h06);
        u_host.send(LRP_CMD_COL_LO | 8'h05);
        tick(1);
        check(48'({state.page, state.column}), 48'h1E5);
        u_host.mem_pulse(1'b1, 1'b0);
        tick(1);
        check(48'({state.page, state.column}), 48'h0);
        u_host.mem_pulse(1'b1, 1'b0);
        u_host.send(LRP_CMD_RMW);
        u_host.mem_pulse(1'b0, 1'b1);
        tick(1);
        check(48'(state.column), 48'h1);
        u_host.send(LRP_CMD_END);
        u_host.mem_pulse(1'b0, 1'b1);
        tick(1);
        check(48'(state.column), 48'h2);
        $display("test address done");

        // Command reset clears everything but never closes the shorts
        u_host.send(LRP_CMD_SEG_REV);
        u_host.send(LRP_CMD_COM | 8'h08);
        u_host.send(LRP_CMD_NL_SET | 8'h03);
        u_host.send(LRP_CMD_LINE | 8'h05);
        u_host.send(LRP_CMD_REVERSE);
        u_host.send(LRP_CMD_RMW);
        u_host.send(LRP_CMD_TEST);
        tick(1);
        check(48'({state.reverse, state.start_line, state.seg_rev,
                   state.com_rev, state.nline_en, state.rmw,
                   state.test_mode}), 48'h4BF);
        u_host.send(LRP_CMD_RESET);
        check(48'({serial_clear, discharge}), 48'h2);
        tick(1);
        check(48'(serial_clear), 48'h0);
        check(48'(state), 48'(init_img()));
        $display("test command reset done");

        // Pin reset: shorts close and commands are ignored while low
        u_host.send(LRP_CMD_DISP_ON);
        u_host.set_power(3'h7);
        tick(1);
        init_low_pin = 1'b0;
        tick(4);
        check(48'({serial_clear, discharge}), 48'h3);
        check(48'(state), 48'(init_img()));
        u_host.send(LRP_CMD_DISP_ON);
        tick(1);
        check(48'(state), 48'(init_img()));
        init_low_pin = 1'b1;
        tick(6);
        check(48'({serial_clear, discharge}), 48'h0);
        $display("test pin reset done");
        test_done();
    end
endmodule
